// *** pkg/srie_pkg.sv ***
// shared constants and types for the stack and return instruction executor
package srie_pkg;
    localparam int PC_W = 21;
    localparam int STK_DEPTH = 31;
    localparam int STK_PTR_W = 5;
    // opcode patterns
    localparam logic [15:0] OP_IDLE = 16'h0000;
    localparam logic [15:0] OP_POP = 16'h0006;
    localparam logic [15:0] OP_PUSH = 16'h0005;
    localparam logic [15:0] OP_SWRST = 16'h00FF;
    localparam logic [14:0] OP_IRET_HI = 15'h0008;
    localparam logic [6:0] OP_NEGATE_FILE_OP_HI = 7'h36;
    localparam logic [4:0] OP_RELATIVE_SUBROUTINE_CALL_HI = 5'h1B;
    localparam logic [3:0] OP_IDLE2_HI = 4'hF;
    // reset values
    localparam logic [PC_W-1:0] PC_RST = 21'h000000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    // flag positions in the status byte
    localparam int FL_C = 0;
    localparam int FL_DC = 1;
    localparam int FL_Z = 2;
    localparam int FL_OV = 3;
    localparam int FL_N = 4;
    // quarter phases of one instruction cycle, gray ordered
    typedef enum logic [1:0] {
        SRIE_Q1 = 2'b00,
        SRIE_Q2 = 2'b01,
        SRIE_Q3 = 2'b11,
        SRIE_Q4 = 2'b10
    } srie_phase_t;
endpackage

// *** pkg/srie_stk_if.sv ***
// return stack command and view bundle
`timescale 1ns/100ps
interface srie_stk_if;
    logic push;
    logic pop;
    logic clear;
    logic [srie_pkg::PC_W-1:0] push_val;
    logic [srie_pkg::PC_W-1:0] top;
    modport core (output push, output pop, output clear, output push_val, input top);
    modport stack (input push, input pop, input clear, input push_val, output top);
endinterface

// *** rtl/srie_exec.sv ***
// executor for negate, idle, stack, relative call, soft reset and interrupt return
// Operation
// - negate file byte, write back same place
// - bank bit zero selects access bank
// - negate updates five flags, one cycle
// - discard top return stack entry
// - push pc plus two onto stack
// - relative call saves pc plus two first
// - target is pc plus two plus 2n
// - relative call takes two cycles
// - soft reset restores all reset values except ir_r, which loads the next word
// - interrupt return pops top into pc
// - interrupt return sets exited priority enable
// - restore bit copies shadows back
// - restore bit zero leaves registers alone
`timescale 1ns/100ps
module srie_exec (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] instr,
    input wire logic [7:0] mem_rdata,
    input wire logic in_high_isr,
    input wire logic [7:0] accumulator_shadow,
    input wire logic [4:0] flags_shadow,
    input wire logic [3:0] bank_shadow,
    output logic [srie_pkg::PC_W-1:0] pc,
    output logic [11:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic [7:0] accumulator,
    output logic [4:0] status_flags,
    output logic [3:0] bank_select_reg,
    output logic high_prio_global_irq_en,
    output logic low_prio_global_irq_en,
    output logic [1:0] phase,
    output logic flush
);
    import srie_pkg::*;
    srie_stk_if stk ();
    srie_ret_stack u_stack (
        .mclk(mclk),
        .rst_b(rst_b),
        .stk(stk)
    );
    ////////////////////////////////////////////////////////////////
    srie_phase_t phase_r, phase_nxt;
    logic [15:0] ir_r;
    logic flush_r;
    logic [PC_W-1:0] pc_r;
    logic [11:0] addr_r;
    logic [7:0] wdata_r, acc_r;
    logic we_r, hie_r, lie_r;
    logic [4:0] flags_r;
    logic [3:0] bank_r;
    logic [1:0] phase_o_r;
    function automatic logic [PC_W-1:0] step_pc(input logic [PC_W-1:0] base);
        step_pc = base + PC_STEP;
    endfunction
    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] base, input logic [10:0] n);
        rel_target = step_pc(base) + {{(PC_W-12){n[10]}}, n, 1'b0};
    endfunction
    ////////////////////////////////////////////////////////////////
    // decode, valid only outside a flush cycle
    wire live = !flush_r;
    wire is_negate_file_op = live && ir_r[15:9] == OP_NEGATE_FILE_OP_HI;
    wire is_pop = live && ir_r == OP_POP;
    wire is_push = live && ir_r == OP_PUSH;
    wire is_relative_subroutine_call = live && ir_r[15:11] == OP_RELATIVE_SUBROUTINE_CALL_HI;
    wire is_swrst = live && ir_r == OP_SWRST;
    wire is_iret = live && ir_r[15:1] == OP_IRET_HI;
    // idle opcodes fall through every decoder above
    wire restore = ir_r[0];
    wire q1 = phase_r == SRIE_Q1;
    wire q2 = phase_r == SRIE_Q2;
    wire q3 = phase_r == SRIE_Q3;
    wire q4 = phase_r == SRIE_Q4;
    // access bank: low half at bank 0, high half at bank 15
    wire [3:0] eff_bank = ir_r[8] ? bank_r : (ir_r[7] ? 4'hF : 4'h0);
    wire [7:0] neg_val = ~mem_rdata + 8'h01;
    wire [8:0] neg_sum = {1'b0, ~mem_rdata} + 9'h001;
    wire [4:0] neg_lo = {1'b0, ~mem_rdata[3:0]} + 5'h01;
    wire neg_ov = (~mem_rdata[7]) && neg_val[7] && mem_rdata != 8'h00 ? 1'b0 : (mem_rdata == 8'h80);
    wire [4:0] neg_flags = {neg_val[7], neg_ov, neg_val == 8'h00, neg_lo[4], neg_sum[8]};
    always_comb begin
        case (phase_r)
            SRIE_Q1: phase_nxt = SRIE_Q2;
            SRIE_Q2: phase_nxt = SRIE_Q3;
            SRIE_Q3: phase_nxt = SRIE_Q4;
            SRIE_Q4: phase_nxt = SRIE_Q1;
            default: phase_nxt = SRIE_Q1;
        endcase
    end
    ////////////////////////////////////////////////////////////////
    // stack commands are single-clock pulses in the documented quarter
    assign stk.push = (q2 && (is_push || is_relative_subroutine_call));
    assign stk.pop = (q3 && is_pop) || (q4 && is_iret);
    assign stk.clear = q4 && is_swrst;
    assign stk.push_val = step_pc(pc_r);
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            phase_r <= SRIE_Q1;
            phase_o_r <= 2'b00;
            ir_r <= OP_IDLE;
            flush_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            phase_o_r <= phase_nxt;
            if (q4) begin
                ir_r <= instr;
                // a taken branch throws away the prefetched word
                flush_r <= is_relative_subroutine_call || is_iret;
            end
        end
    end
    // next values as named wires so each flop block stays short
    wire soft_rst = q4 && is_swrst;
    wire neg_fire = q3 && is_negate_file_op;
    wire iret_fire = q4 && is_iret;
    // restore bit clear keeps live registers
    wire shadow_load = iret_fire && restore;
    wire [PC_W-1:0] pc_jump = is_relative_subroutine_call ? rel_target(pc_r, ir_r[10:0]) : stk.top;
    wire [PC_W-1:0] pc_nxt = !q4 ? pc_r : ((is_relative_subroutine_call || is_iret) ? pc_jump : step_pc(pc_r));
    wire [11:0] addr_nxt = q1 ? {eff_bank, ir_r[7:0]} : addr_r;
    wire [7:0] wdata_nxt = neg_fire ? neg_val : wdata_r;
    wire we_nxt = neg_fire;
    wire [7:0] acc_nxt = shadow_load ? accumulator_shadow : acc_r;
    wire [4:0] flags_nxt = shadow_load ? flags_shadow : (neg_fire ? neg_flags : flags_r);
    wire [3:0] bank_nxt = shadow_load ? bank_shadow : bank_r;
    // re-enable the priority level being left
    wire hie_nxt = hie_r || (iret_fire && in_high_isr);
    wire lie_nxt = lie_r || (iret_fire && !in_high_isr);
    ////////////////////////////////////////////////////////////////
    // soft reset takes the pin reset values within one cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pc_r <= PC_RST;
        end else if (soft_rst) begin
            pc_r <= PC_RST;
        end else begin
            pc_r <= pc_nxt;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            addr_r <= {BANK_RST, BYTE_RST};
        end else if (soft_rst) begin
            addr_r <= {BANK_RST, BYTE_RST};
        end else begin
            addr_r <= addr_nxt;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wdata_r <= BYTE_RST;
        end else if (soft_rst) begin
            wdata_r <= BYTE_RST;
        end else begin
            wdata_r <= wdata_nxt;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            we_r <= 1'b0;
        end else if (soft_rst) begin
            we_r <= 1'b0;
        end else begin
            we_r <= we_nxt;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            acc_r <= BYTE_RST;
        end else if (soft_rst) begin
            acc_r <= BYTE_RST;
        end else begin
            acc_r <= acc_nxt;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= FLAGS_RST;
        end else if (soft_rst) begin
            flags_r <= FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bank_r <= BANK_RST;
        end else if (soft_rst) begin
            bank_r <= BANK_RST;
        end else begin
            bank_r <= bank_nxt;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hie_r <= 1'b0;
        end else if (soft_rst) begin
            hie_r <= 1'b0;
        end else begin
            hie_r <= hie_nxt;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lie_r <= 1'b0;
        end else if (soft_rst) begin
            lie_r <= 1'b0;
        end else begin
            lie_r <= lie_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////
    assign pc = pc_r;
    assign mem_addr = addr_r;
    assign mem_wdata = wdata_r;
    assign mem_we = we_r;
    assign accumulator = acc_r;
    assign status_flags = flags_r;
    assign bank_select_reg = bank_r;
    assign high_prio_global_irq_en = hie_r;
    assign low_prio_global_irq_en = lie_r;
    assign phase = phase_o_r;
    assign flush = flush_r;
endmodule // srie_exec

// *** rtl/srie_ret_stack.sv ***
// hardware return stack
`timescale 1ns/100ps
module srie_ret_stack (
    input wire logic mclk,
    input wire logic rst_b,
    srie_stk_if.stack stk
);
    import srie_pkg::*;
    logic [PC_W-1:0] mem [STK_DEPTH];
    logic [STK_PTR_W-1:0] ptr_r;
    // a push on a full stack is dropped; there is no overflow flag here
    assign stk.top = (ptr_r == '0) ? PC_RST : mem[ptr_r - 5'h01];
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_r <= '0;
        end else if (stk.clear) begin
            ptr_r <= '0;
        end else if (stk.push) begin
            ptr_r <= (ptr_r == 5'(STK_DEPTH)) ? ptr_r : ptr_r + 5'h01;
        end else if (stk.pop && ptr_r != '0) begin
            ptr_r <= ptr_r - 5'h01;
        end
    end
    always_ff @(posedge mclk) begin
        if (stk.push && ptr_r != 5'(STK_DEPTH)) begin
            mem[ptr_r] <= stk.push_val;
        end
    end
endmodule // srie_ret_stack

// *** testbench/srie_exec_assertions.sv ***
// assertions on the executor ports
`timescale 1ns/100ps
module srie_exec_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] mem_rdata,
    input wire logic in_high_isr,
    input wire logic [srie_pkg::PC_W-1:0] pc,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic [4:0] status_flags,
    input wire logic high_prio_global_irq_en,
    input wire logic low_prio_global_irq_en,
    input wire logic [1:0] phase,
    input wire logic flush
);
    import srie_pkg::*;
    wire neg_flags_ok = status_flags[FL_N] == mem_wdata[7] && status_flags[FL_Z] == (mem_wdata == 8'h00);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    sequence s_pulse; mem_we ##1 !mem_we; endsequence
    sequence s_flush; flush [*4] ##1 !flush; endsequence
    a_write_pulse: assert property (mem_we |-> phase == SRIE_Q4 ##0 s_pulse)
        else $error("write is not a single Q4 pulse");
    a_negate_value: assert property (mem_we |-> mem_wdata == 8'(~$past(mem_rdata) + 8'h01))
        else $error("written byte is not the negated read");
    a_negate_flags: assert property (mem_we |-> neg_flags_ok)
        else $error("sign or zero flag wrong after negate");
    a_flush_quiet: assert property (flush |-> !mem_we)
        else $error("write during discarded cycle");
    a_flush_span: assert property ($rose(flush) |-> s_flush)
        else $error("discarded cycle not four clocks");
    a_pc_cycle_end: assert property (phase != SRIE_Q4 |=> $stable(pc))
        else $error("pc moved inside a cycle");
    a_high_cause: assert property ($rose(high_prio_global_irq_en) |-> $past(in_high_isr))
        else $error("high enable set for low exit");
    a_low_cause: assert property ($rose(low_prio_global_irq_en) |-> !$past(in_high_isr))
        else $error("low enable set for high exit");
endmodule // srie_exec_chk
bind srie_exec srie_exec_chk chk_u (
    .mclk(mclk),
    .rst_b(rst_b),
    .mem_rdata(mem_rdata),
    .in_high_isr(in_high_isr),
    .pc(pc),
    .mem_wdata(mem_wdata),
    .mem_we(mem_we),
    .status_flags(status_flags),
    .high_prio_global_irq_en(high_prio_global_irq_en),
    .low_prio_global_irq_en(low_prio_global_irq_en),
    .phase(phase),
    .flush(flush)
);

// *** testbench/srie_exec_tb_top.sv ***
// self-checking bench for the executor
`timescale 1ns/100ps
module srie_exec_tb_top;
    import srie_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] instr = OP_IDLE;
    logic [7:0] mem_rdata = 8'h00;
    logic in_high_isr = 1'b0;
    logic [7:0] accumulator_shadow = 8'h5A;
    logic [4:0] flags_shadow = 5'h15;
    logic [3:0] bank_shadow = 4'h9;
    logic [PC_W-1:0] pc, p, e;
    logic [11:0] mem_addr, wa;
    logic [7:0] mem_wdata, accumulator, wd;
    logic mem_we, high_prio_global_irq_en, low_prio_global_irq_en, flush;
    logic [4:0] status_flags;
    logic [3:0] bank_select_reg;
    logic [1:0] phase;
    int miscompares = 0;
    int checks = 0;
    int writes = 0;
    srie_exec dut_u (
        .mclk(mclk),
        .rst_b(rst_b),
        .instr(instr),
        .mem_rdata(mem_rdata),
        .in_high_isr(in_high_isr),
        .accumulator_shadow(accumulator_shadow),
        .flags_shadow(flags_shadow),
        .bank_shadow(bank_shadow),
        .pc(pc),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_we(mem_we),
        .accumulator(accumulator),
        .status_flags(status_flags),
        .bank_select_reg(bank_select_reg),
        .high_prio_global_irq_en(high_prio_global_irq_en),
        .low_prio_global_irq_en(low_prio_global_irq_en),
        .phase(phase),
        .flush(flush)
    );
    always #20 mclk = ~mclk;
    always @(posedge mclk) if (mem_we === 1'b1) begin
        writes <= writes + 1;
        wa <= mem_addr;
        wd <= mem_wdata;
    end
    ////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [PC_W-1:0] x, input logic [PC_W-1:0] g);
        checks++;
        if (g !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    // op is latched at the end of Q4, nx lands in the following cycle
    task run(input logic [15:0] op, input logic [15:0] nx);
        do @(negedge mclk); while (phase !== SRIE_Q3);
        @(posedge mclk) instr <= op;
        @(posedge mclk) instr <= nx;
        #1 p = pc;
        repeat (4) @(posedge mclk);
        instr <= OP_IDLE;
        #1;
    endtask
    task neg(input logic [7:0] rd, input logic a, input logic [7:0] f, input logic [7:0] x,
             input logic [11:0] ad, input logic [4:0] fl);
        @(posedge mclk) mem_rdata <= rd;
        run({OP_NEGATE_FILE_OP_HI, a, f}, OP_IDLE);
        chk("wdata", x, wd);
        chk("addr", ad, wa);
        chk("flags", fl, status_flags);
    endtask
    task t_stack;
        run(OP_PUSH, OP_IDLE);
        e = p + PC_STEP;
        chk("pc", e, pc);
        run(OP_PUSH, OP_IDLE);
        run(OP_POP, OP_IDLE);
        chk("pc", p + PC_STEP, pc);
        @(posedge mclk) in_high_isr <= 1'b1;
        run(16'h0011, 16'h6C10);
        chk("pc", e, pc);
        chk("hi", 1'b1, high_prio_global_irq_en);
        chk("lo", 1'b0, low_prio_global_irq_en);
        chk("acc", 8'h5A, accumulator);
        chk("st", 5'h15, status_flags);
        chk("bank", 4'h9, bank_select_reg);
    endtask
    task t_relative_subroutine_call(input logic [10:0] n);
        run({OP_RELATIVE_SUBROUTINE_CALL_HI, n}, 16'h6C20);
        e = p + PC_STEP;
        chk("pc", e + {{9{n[10]}}, n, 1'b0}, pc);
        chk("flush", 1'b1, flush);
        @(posedge mclk);
        in_high_isr <= 1'b0;
        // a fresh shadow value shows whether a plain return copied it
        accumulator_shadow <= 8'hC3;
        run(16'h0010, OP_IDLE);
        chk("pc", e, pc);
        chk("lo", 1'b1, low_prio_global_irq_en);
        chk("acc", 8'h5A, accumulator);
        chk("bank", 4'h9, bank_select_reg);
    endtask
    task t_misc;
        run(16'hF123, OP_IDLE);
        chk("pc", p + PC_STEP, pc);
        chk("writes", 3, writes);
        run(OP_SWRST, OP_IDLE);
        chk("pc", PC_RST, pc);
        chk("regs", {BYTE_RST, FLAGS_RST, BANK_RST}, {accumulator, status_flags, bank_select_reg});
        chk("en", 0, {high_prio_global_irq_en, low_prio_global_irq_en});
    endtask
    task end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        neg(8'h3A, 1'b0, 8'h05, 8'hC6, 12'h005, 5'h10);
        neg(8'h00, 1'b1, 8'h90, 8'h00, 12'h090, 5'h07);
        neg(8'h80, 1'b0, 8'h90, 8'h80, 12'hF90, 5'h1A);
        t_stack;
        t_relative_subroutine_call(11'h400);
        t_relative_subroutine_call(11'h3FF);
        t_misc;
        end_sim;
    end
    // the whole run is about a hundred clocks
    initial begin
        #40000;
        miscompares++;
        end_sim;
    end
endmodule // srie_exec_tb_top
